// [common/svpt_pkg.sv]
// constants and types shared by both ends of the point-table command link
package svpt_pkg;
  localparam int DATA_W = 32;
  localparam int PT_COUNT = 15;
  localparam int PT_ATTRS = 6;
  localparam int STAT_ITEMS = 15;
  // command codes
  localparam logic [7:0] CMD_ALM_STAT = 8'h35;
  localparam logic [7:0] CMD_ALM_CLR = 8'h82;
  localparam logic [7:0] CMD_RD_POS = 8'h40;
  localparam logic [7:0] CMD_RD_SPD = 8'h50;
  localparam logic [7:0] CMD_RD_ACC = 8'h54;
  localparam logic [7:0] CMD_RD_DEC = 8'h58;
  localparam logic [7:0] CMD_RD_DWL = 8'h60;
  localparam logic [7:0] CMD_RD_AUX = 8'h64;
  localparam logic [7:0] CMD_WR_POS = 8'hc0;
  localparam logic [7:0] CMD_WR_SPD = 8'hc6;
  localparam logic [7:0] CMD_WR_ACC = 8'hc7;
  localparam logic [7:0] CMD_WR_DEC = 8'hc8;
  localparam logic [7:0] CMD_WR_DWL = 8'hca;
  localparam logic [7:0] CMD_WR_AUX = 8'hcb;
  localparam logic [7:0] CMD_GRP_WR = 8'h9f;
  localparam logic [7:0] CMD_GRP_RD = 8'h1f;
  localparam logic [7:0] CMD_STAT_RD = 8'h02;
  // data numbers and keys
  localparam logic [7:0] DNO_ZERO = 8'h00;
  localparam logic [7:0] DNO_STAT_LO = 8'h80;
  localparam logic [7:0] DNO_STAT_HI = 8'h8e;
  localparam logic [7:0] DNO_PT_LO = 8'h01;
  localparam logic [7:0] DNO_PT_HI = 8'h0f;
  localparam logic [7:0] DNO_ABS_PULSE = 8'h90;
  localparam logic [7:0] DNO_ABS_CMDU = 8'h91;
  localparam logic [15:0] ALM_CLR_KEY = 16'h1ea5;
  localparam logic [7:0] GROUP_NONE = 8'h00;
  // write mode field
  localparam logic WMODE_NV_RAM = 1'b0;
  localparam logic WMODE_RAM = 1'b1;
  // rewrite interval below which the master keeps to RAM mode
  localparam longint HOUR_S = 3600;
  localparam longint CLK_HZ = 50000000;
  localparam longint HOUR_CYC = HOUR_S * CLK_HZ;
  typedef enum logic [2:0] {
    ATTR_POS = 3'h0,
    ATTR_SPD = 3'h1,
    ATTR_ACC = 3'h2,
    ATTR_DEC = 3'h3,
    ATTR_DWL = 3'h4,
    ATTR_AUX = 3'h5
  } svpt_attr_t;
endpackage

// [common/svpt_if.sv]
// command/reply link between master station and servo slave station
`timescale 1ns/1ps
`default_nettype none
interface svpt_if;
  import svpt_pkg::*;
  logic req_valid;
  logic req_ready;
  logic [7:0] req_addr;
  logic [7:0] req_cmd;
  logic [7:0] req_dno;
  logic req_wmode;
  logic [DATA_W-1:0] req_data;
  logic rsp_valid;
  logic rsp_ready;
  logic rsp_err;
  logic rsp_rd_dis;
  logic [DATA_W-1:0] rsp_data;
  modport dev (
    input req_valid, req_addr, req_cmd, req_dno, req_wmode, req_data, rsp_ready,
    output req_ready, rsp_valid, rsp_err, rsp_rd_dis, rsp_data
  );
  modport host (
    output req_valid, req_addr, req_cmd, req_dno, req_wmode, req_data, rsp_ready,
    input req_ready, rsp_valid, rsp_err, rsp_rd_dis, rsp_data
  );
endinterface
`default_nettype wire

// [core/svpt_device.sv]
// slave station command handler: alarm, point table, group, position reads
`timescale 1ns/1ps
`default_nettype none
module svpt_device
  import svpt_pkg::*;
#(
  parameter int NTBL = PT_COUNT
)
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // link to master
  svpt_if.dev lnk,
  // station identity
  input wire logic [7:0] STATION_ID,
  // alarm and status
  input wire logic ALARM_ACTIVE,
  input wire logic [STAT_ITEMS-1:0][DATA_W-1:0] STAT_IN,
  output logic ALARM_RESET_INPUT,
  // position feedback
  input wire logic [DATA_W-1:0] ABS_PULSE,
  input wire logic [DATA_W-1:0] ABS_CMDU,
  // per-table read disable
  input wire logic [NTBL-1:0] READ_LOCK,
  // nonvolatile store write port
  output logic NV_WE,
  output logic [2:0] NV_ATTR,
  output logic [3:0] NV_TBL,
  output logic [DATA_W-1:0] NV_DATA,
  // current group designation
  output logic [DATA_W-1:0] CUR_GROUP
);

  // refuse table counts the index decode cannot serve
  if (NTBL < 1 || NTBL > PT_COUNT)
  begin : g_ntbl_check
    $error("NTBL out of range");
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic pt_dno_ok(input logic [7:0] dno);
    pt_dno_ok = (dno >= DNO_PT_LO) && (dno <= DNO_PT_HI) && (dno <= 8'(NTBL));
  endfunction

  function automatic logic [3:0] pt_index(input logic [7:0] dno);
    pt_index = dno[3:0] - 4'h1;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] pt_ff [PT_ATTRS][NTBL];
  logic [DATA_W-1:0] stat_ff [STAT_ITEMS];
  logic [7:0] group_ff;
  logic alarm_ff;
  logic rsp_valid_ff;
  logic rsp_err_ff;
  logic rsp_rd_dis_ff;
  logic [DATA_W-1:0] rsp_data_ff;
  logic clr_ff;
  logic nv_we_ff;
  logic [2:0] nv_attr_ff;
  logic [3:0] nv_tbl_ff;
  logic [DATA_W-1:0] nv_data_ff;

  logic take;
  logic to_me;
  logic to_group;
  logic nxt_err;
  logic nxt_rd_dis;
  logic [DATA_W-1:0] nxt_data;
  logic wr_en;
  logic [2:0] wr_attr;
  logic clr_en;
  logic grp_we;

  assign lnk.req_ready = ~rsp_valid_ff;
  assign take = lnk.req_valid & lnk.req_ready;
  assign to_me = lnk.req_addr == STATION_ID;
  assign to_group = (group_ff != GROUP_NONE) && (lnk.req_addr == group_ff);

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_err = 1'b0;
    nxt_rd_dis = 1'b0;
    nxt_data = '0;
    wr_en = 1'b0;
    wr_attr = ATTR_POS;
    clr_en = 1'b0;
    grp_we = 1'b0;
    unique case (lnk.req_cmd)
      CMD_ALM_STAT:
      begin
        if (lnk.req_dno >= DNO_STAT_LO && lnk.req_dno <= DNO_STAT_HI)
        begin
          nxt_data = stat_ff[lnk.req_dno[3:0]];
        end
        else
        begin
          nxt_err = 1'b1;
        end
      end
      CMD_ALM_CLR:
      begin
        if (lnk.req_dno == DNO_ZERO && lnk.req_data[15:0] == ALM_CLR_KEY)
        begin
          clr_en = 1'b1;
        end
        else
        begin
          nxt_err = 1'b1;
        end
      end
      CMD_RD_POS, CMD_RD_SPD, CMD_RD_ACC, CMD_RD_DEC, CMD_RD_DWL, CMD_RD_AUX:
      begin
        unique case (lnk.req_cmd)
          CMD_RD_POS: wr_attr = ATTR_POS;
          CMD_RD_SPD: wr_attr = ATTR_SPD;
          CMD_RD_ACC: wr_attr = ATTR_ACC;
          CMD_RD_DEC: wr_attr = ATTR_DEC;
          CMD_RD_DWL: wr_attr = ATTR_DWL;
          default: wr_attr = ATTR_AUX;
        endcase
        if (pt_dno_ok(lnk.req_dno))
        begin
          nxt_data = pt_ff[wr_attr][pt_index(lnk.req_dno)];
          nxt_rd_dis = READ_LOCK[pt_index(lnk.req_dno)];
        end
        else
        begin
          nxt_err = 1'b1;
        end
      end
      CMD_WR_POS, CMD_WR_SPD, CMD_WR_ACC, CMD_WR_DEC, CMD_WR_DWL, CMD_WR_AUX:
      begin
        unique case (lnk.req_cmd)
          CMD_WR_POS: wr_attr = ATTR_POS;
          CMD_WR_SPD: wr_attr = ATTR_SPD;
          CMD_WR_ACC: wr_attr = ATTR_ACC;
          CMD_WR_DEC: wr_attr = ATTR_DEC;
          CMD_WR_DWL: wr_attr = ATTR_DWL;
          default: wr_attr = ATTR_AUX;
        endcase
        wr_en = pt_dno_ok(lnk.req_dno);
        nxt_err = ~pt_dno_ok(lnk.req_dno);
      end
      CMD_GRP_WR:
      begin
        grp_we = lnk.req_dno == DNO_ZERO;
        nxt_err = lnk.req_dno != DNO_ZERO;
      end
      CMD_GRP_RD:
      begin
        nxt_data = DATA_W'(group_ff);
        nxt_err = lnk.req_dno != DNO_ZERO;
      end
      CMD_STAT_RD:
      begin
        if (lnk.req_dno == DNO_ABS_PULSE)
        begin
          nxt_data = ABS_PULSE;
        end
        else if (lnk.req_dno == DNO_ABS_CMDU)
        begin
          nxt_data = ABS_CMDU;
        end
        else
        begin
          nxt_err = 1'b1;
        end
      end
      default:
      begin
        nxt_err = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // point table working RAM
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      for (int a = 0; a < PT_ATTRS; a++)
      begin
        for (int t = 0; t < NTBL; t++)
        begin
          pt_ff[a][t] <= '0;
        end
      end
    end
    else if (take && (to_me || to_group) && wr_en)
    begin
      pt_ff[wr_attr][pt_index(lnk.req_dno)] <= lnk.req_data;
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile write strobe, only in mode 0
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      nv_we_ff <= 1'b0;
      nv_attr_ff <= '0;
      nv_tbl_ff <= '0;
      nv_data_ff <= '0;
    end
    else
    begin
      nv_we_ff <= take && (to_me || to_group) && wr_en && (lnk.req_wmode == WMODE_NV_RAM);
      if (take && wr_en)
      begin
        nv_attr_ff <= wr_attr;
        nv_tbl_ff <= pt_index(lnk.req_dno);
        nv_data_ff <= lnk.req_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // alarm snapshot and clear
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      alarm_ff <= 1'b0;
      for (int i = 0; i < STAT_ITEMS; i++)
      begin
        stat_ff[i] <= '0;
      end
    end
    else
    begin
      alarm_ff <= ALARM_ACTIVE;
      if (ALARM_ACTIVE && !alarm_ff)
      begin
        for (int i = 0; i < STAT_ITEMS; i++)
        begin
          stat_ff[i] <= STAT_IN[i];
        end
      end
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      clr_ff <= 1'b0;
    end
    else
    begin
      clr_ff <= take && (to_me || to_group) && clr_en;
    end
  end

  // ----------------------------------------------------------------
  // group designation
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      group_ff <= GROUP_NONE;
    end
    else if (take && (to_me || to_group) && grp_we)
    begin
      group_ff <= lnk.req_data[7:0];
    end
  end

  // ----------------------------------------------------------------
  // reply, held until the master takes it; group frames get none
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      rsp_valid_ff <= 1'b0;
      rsp_err_ff <= 1'b0;
      rsp_rd_dis_ff <= 1'b0;
      rsp_data_ff <= '0;
    end
    else if (take && to_me)
    begin
      rsp_valid_ff <= 1'b1;
      rsp_err_ff <= nxt_err;
      rsp_rd_dis_ff <= nxt_rd_dis;
      rsp_data_ff <= nxt_data;
    end
    else if (rsp_valid_ff && lnk.rsp_ready)
    begin
      rsp_valid_ff <= 1'b0;
    end
  end

  assign lnk.rsp_valid = rsp_valid_ff;
  assign lnk.rsp_err = rsp_err_ff;
  assign lnk.rsp_rd_dis = rsp_rd_dis_ff;
  assign lnk.rsp_data = rsp_data_ff;
  assign ALARM_RESET_INPUT = clr_ff;
  assign NV_WE = nv_we_ff;
  assign NV_ATTR = nv_attr_ff;
  assign NV_TBL = nv_tbl_ff;
  assign NV_DATA = nv_data_ff;
  assign CUR_GROUP = DATA_W'(group_ff);

endmodule
`default_nettype wire

// [core/svpt_host.sv]
// master station end: issues one command and collects its reply
`timescale 1ns/1ps
`default_nettype none
module svpt_host
  import svpt_pkg::*;
#(
  parameter longint NV_GAP_CYC = HOUR_CYC
)
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // link to slave
  svpt_if.host lnk,
  // user command
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [7:0] CMD_ADDR,
  input wire logic CMD_GROUP,
  input wire logic [7:0] CMD_CODE,
  input wire logic [7:0] CMD_DNO,
  input wire logic CMD_WMODE,
  input wire logic [DATA_W-1:0] CMD_DATA,
  // alarm-clear preconditions
  input wire logic CAUSE_REMOVED,
  input wire logic OP_CMD_ACTIVE,
  // user result
  output logic RES_VALID,
  output logic RES_ERR,
  output logic RES_UNREADABLE,
  output logic [DATA_W-1:0] RES_DATA
);

  // a zero gap would never hold a write back from nonvolatile memory
  if (NV_GAP_CYC < 1)
  begin : g_gap_check
    $error("NV_GAP_CYC must be positive");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b100
  } svpt_hst_t;

  svpt_hst_t state_ff;
  logic [7:0] addr_ff;
  logic [7:0] cmd_ff;
  logic [7:0] dno_ff;
  logic wmode_ff;
  logic grp_ff;
  logic [DATA_W-1:0] data_ff;
  logic [39:0] nv_age_ff;
  logic res_valid_ff;
  logic res_err_ff;
  logic res_unrd_ff;
  logic [DATA_W-1:0] res_data_ff;
  logic is_clr;
  logic clr_refused;
  logic is_wr;

  assign is_clr = CMD_CODE == CMD_ALM_CLR && CMD_DNO == DNO_ZERO;
  assign clr_refused = is_clr && (!CAUSE_REMOVED || OP_CMD_ACTIVE);
  assign is_wr = CMD_CODE[7:4] == CMD_WR_POS[7:4];
  assign CMD_READY = state_ff == ST_IDLE;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      state_ff <= ST_IDLE;
      addr_ff <= '0;
      cmd_ff <= '0;
      dno_ff <= '0;
      wmode_ff <= WMODE_RAM;
      grp_ff <= 1'b0;
      data_ff <= '0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          if (CMD_VALID && !clr_refused)
          begin
            state_ff <= ST_SEND;
            addr_ff <= CMD_ADDR;
            cmd_ff <= CMD_CODE;
            dno_ff <= CMD_DNO;
            grp_ff <= CMD_GROUP;
            data_ff <= CMD_DATA;
            // keep frequent rewrites out of nonvolatile memory
            wmode_ff <= (is_wr && nv_age_ff < 40'(NV_GAP_CYC)) ? WMODE_RAM : CMD_WMODE;
          end
        end
        ST_SEND:
        begin
          if (lnk.req_ready)
          begin
            state_ff <= grp_ff ? ST_IDLE : ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (lnk.rsp_valid)
          begin
            state_ff <= ST_IDLE;
          end
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // time since the last nonvolatile-mode write, saturating
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      nv_age_ff <= '1;
    end
    else if (state_ff == ST_SEND && lnk.req_ready && cmd_ff[7:4] == CMD_WR_POS[7:4] && wmode_ff == WMODE_NV_RAM)
    begin
      nv_age_ff <= '0;
    end
    else if (nv_age_ff != '1)
    begin
      nv_age_ff <= nv_age_ff + 40'h1;
    end
  end

  // ----------------------------------------------------------------
  // result
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      res_valid_ff <= 1'b0;
      res_err_ff <= 1'b0;
      res_unrd_ff <= 1'b0;
      res_data_ff <= '0;
    end
    else
    begin
      res_valid_ff <= 1'b0;
      if (state_ff == ST_IDLE && CMD_VALID && clr_refused)
      begin
        res_valid_ff <= 1'b1;
        res_err_ff <= 1'b1;
        res_unrd_ff <= 1'b0;
        res_data_ff <= '0;
      end
      else if (state_ff == ST_WAIT && lnk.rsp_valid)
      begin
        res_valid_ff <= 1'b1;
        res_err_ff <= lnk.rsp_err;
        res_unrd_ff <= lnk.rsp_rd_dis;
        res_data_ff <= lnk.rsp_rd_dis ? '0 : lnk.rsp_data;
      end
    end
  end

  assign lnk.req_valid = state_ff == ST_SEND;
  assign lnk.req_addr = addr_ff;
  assign lnk.req_cmd = cmd_ff;
  assign lnk.req_dno = dno_ff;
  assign lnk.req_wmode = wmode_ff;
  assign lnk.req_data = data_ff;
  assign lnk.rsp_ready = state_ff == ST_WAIT;
  assign RES_VALID = res_valid_ff;
  assign RES_ERR = res_err_ff;
  assign RES_UNREADABLE = res_unrd_ff;
  assign RES_DATA = res_data_ff;

endmodule
`default_nettype wire

// [bench/svpt_sva.sv]
// concurrent checks on the master-to-slave command link
`timescale 1ns/1ps
`default_nettype none
module svpt_sva
  import svpt_pkg::*;
#(
  parameter logic [7:0] OWN_ID = 8'h01
)
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // request side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_cmd,
  input wire logic [7:0] req_dno,
  input wire logic req_wmode,
  input wire logic [DATA_W-1:0] req_data,
  // reply side
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic rsp_err,
  input wire logic rsp_rd_dis,
  input wire logic [DATA_W-1:0] rsp_data
);
  logic take;
  logic pt_cmd;
  logic pt_in;
  assign take = req_valid && req_ready && req_addr == OWN_ID;
  assign pt_cmd = req_cmd inside {CMD_RD_POS, CMD_RD_SPD, CMD_RD_ACC, CMD_RD_DEC, CMD_RD_DWL, CMD_RD_AUX,
    CMD_WR_POS, CMD_WR_SPD, CMD_WR_ACC, CMD_WR_DEC, CMD_WR_DWL, CMD_WR_AUX};
  assign pt_in = req_dno >= DNO_PT_LO && req_dno <= DNO_PT_HI;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);
  // ----------------------------------------
  // reply handshake
  // ----------------------------------------
  property p_answer;
    take |=> rsp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no reply one cycle after own request");
  property p_group_silent;
    req_valid && req_ready && req_addr != OWN_ID |=> !rsp_valid;
  endproperty
  a_group_silent: assert property (p_group_silent) else $error("reply to a group frame");
  property p_hold;
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_err);
  endproperty
  a_hold: assert property (p_hold) else $error("reply dropped before accepted");
  property p_release;
    rsp_valid && rsp_ready |=> !rsp_valid && req_ready;
  endproperty
  a_release: assert property (p_release) else $error("reply not released after acceptance");
  property p_refuse;
    rsp_valid |-> !req_ready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("request accepted while reply pending");
  // ----------------------------------------
  // command decoding
  // ----------------------------------------
  property p_stat_range;
    take && req_cmd == CMD_ALM_STAT && (req_dno < DNO_STAT_LO || req_dno > DNO_STAT_HI) |=> rsp_err;
  endproperty
  a_stat_range: assert property (p_stat_range) else $error("status item out of range accepted");
  property p_clr_key;
    take && req_cmd == CMD_ALM_CLR && (req_dno != DNO_ZERO || req_data[15:0] != ALM_CLR_KEY) |=> rsp_err;
  endproperty
  a_clr_key: assert property (p_clr_key) else $error("alarm clear without key accepted");
  property p_pt_range;
    take && pt_cmd && !pt_in |=> rsp_err;
  endproperty
  a_pt_range: assert property (p_pt_range) else $error("bad table number accepted");
  property p_pt_ok;
    take && pt_cmd && pt_in |=> !rsp_err;
  endproperty
  a_pt_ok: assert property (p_pt_ok) else $error("valid table command refused");
  property p_grp_dno;
    take && (req_cmd == CMD_GRP_WR || req_cmd == CMD_GRP_RD) && req_dno != DNO_ZERO |=> rsp_err;
  endproperty
  a_grp_dno: assert property (p_grp_dno) else $error("group command with bad number accepted");
  property p_abs_ok;
    take && req_cmd == CMD_STAT_RD && (req_dno == DNO_ABS_PULSE || req_dno == DNO_ABS_CMDU) |=> !rsp_err;
  endproperty
  a_abs_ok: assert property (p_abs_ok) else $error("position read refused");
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the point-table command link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import svpt_pkg::*;
  localparam logic [7:0] ID = 8'h05;
  localparam logic [7:0] GRP = 8'h21;
  localparam logic [7:0] WR [6] = '{CMD_WR_POS, CMD_WR_SPD, CMD_WR_ACC, CMD_WR_DEC, CMD_WR_DWL, CMD_WR_AUX};
  localparam logic [7:0] RD [6] = '{CMD_RD_POS, CMD_RD_SPD, CMD_RD_ACC, CMD_RD_DEC, CMD_RD_DWL, CMD_RD_AUX};
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  logic [7:0] cmd_addr = 8'h00;
  logic cmd_group = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [7:0] cmd_dno = 8'h00;
  logic cmd_wmode = 1'b1;
  logic [DATA_W-1:0] cmd_data = '0;
  logic cause_removed = 1'b1;
  logic op_cmd_active = 1'b0;
  logic res_valid;
  logic res_err;
  logic res_unr;
  logic [DATA_W-1:0] res_data;
  logic alarm_active = 1'b0;
  logic [STAT_ITEMS-1:0][DATA_W-1:0] stat_in;
  logic alarm_reset_input;
  logic [DATA_W-1:0] abs_pulse = 32'h000186a0;
  logic [DATA_W-1:0] abs_cmdu = 32'h00004e20;
  logic [PT_COUNT-1:0] read_lock = 15'h0002;
  logic nv_we;
  logic [2:0] nv_attr;
  logic [3:0] nv_tbl;
  logic [DATA_W-1:0] nv_data;
  logic [DATA_W-1:0] cur_group;
  logic r_err;
  logic r_unr;
  logic [DATA_W-1:0] r_data;
  logic [DATA_W-1:0] nv_l = '0;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int nv_cnt = 0;
  int clr_cnt = 0;
  svpt_if lnk ();
  svpt_device #(.NTBL(PT_COUNT)) u_svpt_device (.MCLK(mclk), .RESET(reset), .lnk(lnk.dev), .STATION_ID(ID),
    .ALARM_ACTIVE(alarm_active), .STAT_IN(stat_in), .ALARM_RESET_INPUT(alarm_reset_input), .ABS_PULSE(abs_pulse),
    .ABS_CMDU(abs_cmdu), .READ_LOCK(read_lock), .NV_WE(nv_we), .NV_ATTR(nv_attr), .NV_TBL(nv_tbl),
    .NV_DATA(nv_data), .CUR_GROUP(cur_group));
  svpt_host #(.NV_GAP_CYC(20)) u_svpt_host (.MCLK(mclk), .RESET(reset), .lnk(lnk.host), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_ADDR(cmd_addr), .CMD_GROUP(cmd_group), .CMD_CODE(cmd_code), .CMD_DNO(cmd_dno),
    .CMD_WMODE(cmd_wmode), .CMD_DATA(cmd_data), .CAUSE_REMOVED(cause_removed), .OP_CMD_ACTIVE(op_cmd_active),
    .RES_VALID(res_valid), .RES_ERR(res_err), .RES_UNREADABLE(res_unr), .RES_DATA(res_data));
  svpt_sva #(.OWN_ID(ID)) u_svpt_sva (.MCLK(mclk), .RESET(reset), .req_valid(lnk.req_valid),
    .req_ready(lnk.req_ready), .req_addr(lnk.req_addr), .req_cmd(lnk.req_cmd), .req_dno(lnk.req_dno),
    .req_wmode(lnk.req_wmode), .req_data(lnk.req_data), .rsp_valid(lnk.rsp_valid), .rsp_ready(lnk.rsp_ready),
    .rsp_err(lnk.rsp_err), .rsp_rd_dis(lnk.rsp_rd_dis), .rsp_data(lnk.rsp_data));
  // ----------------------------------------
  // clock, monitors and timeout
  // ----------------------------------------
  initial
  begin
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (nv_we === 1'b1)
    begin
      nv_cnt++;
      nv_l <= {nv_attr, nv_tbl, nv_data[24:0]};
    end
    if (alarm_reset_input === 1'b1)
      clr_cnt++;
    if (cyc == 20000)
    begin
      mismatches++;
      results();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic results();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_data(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] act);
    compares++;
    if (act !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask
  task automatic chk_bit(input logic exp, input logic act);
    compares++;
    if (act !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask
  task automatic send(input logic [7:0] a, input logic g, input logic [7:0] c, input logic [7:0] d,
    input logic w, input logic [DATA_W-1:0] v);
    int n;
    n = 0;
    @(negedge mclk);
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(negedge mclk);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_addr = a;
    cmd_group = g;
    cmd_code = c;
    cmd_dno = d;
    cmd_wmode = w;
    cmd_data = v;
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    if (g)
      repeat (4) @(negedge mclk);
    else
    begin
      while (res_valid !== 1'b1 && n < 50)
      begin
        @(negedge mclk);
        n++;
      end
      chk_bit(1'b1, res_valid);
      r_err = res_err;
      r_unr = res_unr;
      r_data = res_data;
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] d);
    send(ID, 1'b0, c, d, WMODE_RAM, '0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_tables();
    for (int a = 0; a < 6; a++)
    begin
      send(ID, 1'b0, WR[a], DNO_PT_LO, WMODE_RAM, 32'h11000000 + a);
      send(ID, 1'b0, WR[a], DNO_PT_HI, WMODE_RAM, 32'h22000000 + a);
    end
    chk_data(32'h0, nv_cnt);
    for (int a = 0; a < 6; a++)
    begin
      rd(RD[a], DNO_PT_LO);
      chk_data(32'h11000000 + a, r_data);
      rd(RD[a], DNO_PT_HI);
      chk_data(32'h22000000 + a, r_data);
    end
  endtask
  task automatic t_nv();
    send(ID, 1'b0, CMD_WR_SPD, 8'h03, WMODE_NV_RAM, 32'h00003a3a);
    @(negedge mclk);
    chk_data(32'h1, nv_cnt);
    chk_data({ATTR_SPD, 4'h2, 25'h3a3a}, nv_l);
    send(ID, 1'b0, CMD_WR_ACC, 8'h03, WMODE_NV_RAM, 32'h00000444);
    rd(CMD_RD_ACC, 8'h03);
    chk_data(32'h00000444, r_data);
    chk_data(32'h1, nv_cnt);
    repeat (25) @(negedge mclk);
    send(ID, 1'b0, CMD_WR_DWL, 8'h03, WMODE_NV_RAM, 32'h00000055);
    @(negedge mclk);
    chk_data(32'h2, nv_cnt);
  endtask
  task automatic t_lock_bad();
    send(ID, 1'b0, CMD_WR_POS, 8'h02, WMODE_RAM, 32'h00abcdef);
    rd(CMD_RD_POS, 8'h02);
    chk_bit(1'b1, r_unr);
    chk_data(32'h0, r_data);
    send(ID, 1'b0, CMD_WR_POS, DNO_ZERO, WMODE_RAM, 32'hffffffff);
    chk_bit(1'b1, r_err);
    rd(CMD_RD_SPD, 8'h10);
    chk_bit(1'b1, r_err);
    rd(CMD_RD_POS, DNO_PT_LO);
    chk_data(32'h11000000, r_data);
    rd(CMD_ALM_STAT, 8'h8f);
    chk_bit(1'b1, r_err);
    rd(CMD_GRP_RD, 8'h01);
    chk_bit(1'b1, r_err);
  endtask
  task automatic t_alarm();
    @(negedge mclk);
    alarm_active = 1'b1;
    repeat (3) @(negedge mclk);
    for (int i = 0; i < STAT_ITEMS; i++)
      stat_in[i] = 32'hffffffff;
    rd(CMD_ALM_STAT, DNO_STAT_LO);
    chk_data(32'h5a000000, r_data);
    rd(CMD_ALM_STAT, DNO_STAT_HI);
    chk_data(32'h5a00000e, r_data);
    cause_removed = 1'b0;
    send(ID, 1'b0, CMD_ALM_CLR, DNO_ZERO, WMODE_RAM, {16'h0, ALM_CLR_KEY});
    chk_bit(1'b1, r_err);
    cause_removed = 1'b1;
    op_cmd_active = 1'b1;
    send(ID, 1'b0, CMD_ALM_CLR, DNO_ZERO, WMODE_RAM, {16'h0, ALM_CLR_KEY});
    chk_bit(1'b1, r_err);
    op_cmd_active = 1'b0;
    send(ID, 1'b0, CMD_ALM_CLR, DNO_ZERO, WMODE_RAM, 32'h00001ea4);
    chk_bit(1'b1, r_err);
    chk_data(32'h0, clr_cnt);
    send(ID, 1'b0, CMD_ALM_CLR, DNO_ZERO, WMODE_RAM, {16'h0, ALM_CLR_KEY});
    chk_bit(1'b0, r_err);
    chk_data(32'h1, clr_cnt);
  endtask
  task automatic t_group_abs();
    send(ID, 1'b0, CMD_GRP_WR, DNO_ZERO, WMODE_RAM, {24'h0, GRP});
    rd(CMD_GRP_RD, DNO_ZERO);
    chk_data({24'h0, GRP}, r_data);
    chk_data({24'h0, GRP}, cur_group);
    send(GRP, 1'b1, CMD_WR_DWL, 8'h05, WMODE_RAM, 32'h00000077);
    send(8'h06, 1'b1, CMD_WR_DWL, 8'h05, WMODE_RAM, 32'h00000099);
    rd(CMD_RD_DWL, 8'h05);
    chk_data(32'h00000077, r_data);
    rd(CMD_STAT_RD, DNO_ABS_PULSE);
    chk_data(32'h000186a0, r_data);
    rd(CMD_STAT_RD, DNO_ABS_CMDU);
    chk_data(32'h00004e20, r_data);
  endtask
  initial
  begin
    for (int i = 0; i < STAT_ITEMS; i++)
      stat_in[i] = 32'h5a000000 + i;
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    t_tables();
    t_nv();
    t_lock_bad();
    t_alarm();
    t_group_abs();
    results();
  end
endmodule
`default_nettype wire
